// ### verilog/pin_mux_pkg.sv
package pin_mux_pkg;
  localparam int PIN_COUNT = 19;
  localparam int GROUP_COUNT = 5;
  localparam int GROUP_SIZE = 4;
  localparam int WORD_W = 8;
  localparam int SYNC_STAGES = 3;

  // function codes per group of four pins
  localparam logic [3:0] FUNC_WATCH = 4'h0;
  localparam logic [3:0] FUNC_MANUAL = 4'h3;
  localparam logic [3:0] FUNC_CPU = 4'h9;
  localparam logic [3:0] FUNC_SLICER = 4'hA;
  localparam logic [3:0] FUNC_RESET = 4'h0;

  // watch set indices
  localparam logic [7:0] WATCH_SET_A = 8'h01;
  localparam logic [7:0] WATCH_SET_B = 8'h02;
  localparam logic [7:0] WATCH_SET_D = 8'h04;

  // register offsets
  localparam logic [3:0] REG_OE = 4'h0;
  localparam logic [3:0] REG_FUNC = 4'h1;
  localparam logic [3:0] REG_WATCH_IDX = 4'h2;
  localparam logic [3:0] REG_WATCH_MASK = 4'h3;
  localparam logic [3:0] REG_PIN_OUT = 4'h4;
  localparam logic [3:0] REG_PIN_IN = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;
  localparam logic [3:0] REG_WATCH_WORD = 4'h8;

  localparam logic [18:0] OE_RESET = 19'h00000;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] IDX_RESET = 8'h00;

  // per-channel gain loop status
  typedef struct packed {
    logic gain_change;
    logic gain_inc;
    logic gain_dec;
    logic peak_hi_cnt;
    logic peak_hi;
    logic hb_hi_cnt;
    logic hb_hi;
    logic hb_lo_cnt;
    logic low_power;
    logic high_power;
    logic update_expiry;
  } chan_status_t;

  typedef struct packed {
    logic [18:0] oe;
    logic [19:0] func;
    logic [7:0] watch_idx;
    logic [7:0] watch_mask;
    logic [18:0] pin_out;
    logic [18:0] pin_out_r;
    logic [18:0] pin_oe_n;
    logic [18:0] sync1;
    logic [18:0] sync2;
    logic [18:0] sync3;
    logic [18:0] pin_in;
    logic [18:0] irq_stat;
    logic [18:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } state_t;
endpackage : pin_mux_pkg

// ### verilog/pin_function_mux.sv
// Behaviour
// - each pin direction from own enable
// - one function per group of four
// - code 0 drives watch word out
// - code 3 manual drive and readback
// - code 9 connects embedded processor pins
// - code 10 connects slicer data pins
// - pin index equals pin number 0-18
// - watch word on pins 0-7, 8-15
// - pins 16-18 carry word bits 4-6
// - watch bit needs group and enable
// - watch word ANDed with mask
// - index picks the watch signal set
// - set a bit layout of index 1
// - sets b and d bit layouts
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pin_function_mux (
  input wire logic CLK_SYS, // 10 MHz system clock
  input wire logic NRST, // synchronous reset, active low
  input wire logic CE, // clock enable, freezes state when low
  input wire logic [3:0] ADDR, // register word address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after strobe
  input wire pin_mux_pkg::chan_status_t CH1, // channel 1 gain loop status
  input wire pin_mux_pkg::chan_status_t CH2, // channel 2 gain loop status
  input wire logic [18:0] CPU_OUT, // embedded processor pin levels
  input wire logic [18:0] SLICER_OUT, // slicer pin levels
  output logic [18:0] CPU_IN, // pins seen by embedded processor
  input wire logic [18:0] PIN_I, // pin input levels
  output logic [18:0] PIN_O, // pin output levels
  output logic [18:0] PIN_OE_N, // pin output enable, low drives
  output logic IRQ // level interrupt
);
  pin_mux_pkg::state_t s_q, s_d;
  logic [7:0] word_raw;
  logic [7:0] word;
  logic [18:0] pin_drive;

  // watch word selection; unlisted positions stay zero
  always_comb begin
    word_raw = 8'h00;
    case (s_q.watch_idx)
      pin_mux_pkg::WATCH_SET_A: begin
        word_raw = {CH2.gain_change, CH1.gain_change, CH2.peak_hi_cnt, CH1.peak_hi_cnt,
                    CH2.hb_hi_cnt, CH1.hb_hi_cnt, CH2.hb_lo_cnt, CH1.hb_lo_cnt};
      end
      pin_mux_pkg::WATCH_SET_B: begin
        word_raw = {CH2.gain_change, CH1.gain_change, CH2.peak_hi, CH1.peak_hi,
                    CH2.hb_hi, CH1.hb_hi, 2'h0};
      end
      pin_mux_pkg::WATCH_SET_D: begin
        word_raw = {CH1.low_power, CH1.high_power, CH1.update_expiry, 2'h0,
                    CH1.gain_change, CH1.gain_inc, CH1.gain_dec};
      end
      default: begin
        word_raw = 8'h00;
      end
    endcase
  end

  assign word = word_raw & s_q.watch_mask;

  // per pin source selection from its group code
  always_comb begin
    pin_drive = '0;
    for (int p = 0; p < pin_mux_pkg::PIN_COUNT; p++) begin
      case (s_q.func[(p / pin_mux_pkg::GROUP_SIZE) * 4 +: 4])
        pin_mux_pkg::FUNC_WATCH: pin_drive[p] = (p < 16) ? word[p % 8] : word[p - 12];
        pin_mux_pkg::FUNC_MANUAL: pin_drive[p] = s_q.pin_out[p];
        pin_mux_pkg::FUNC_CPU: pin_drive[p] = CPU_OUT[p];
        pin_mux_pkg::FUNC_SLICER: pin_drive[p] = SLICER_OUT[p];
        default: pin_drive[p] = 1'b0;
      endcase
    end
  end

  // next state: bus, sync, sticky pin-change events
  always_comb begin
    logic [18:0] changed;
    s_d = s_q;
    changed = '0;
    // three-stage sync, change accepted when stages two and three agree
    s_d.sync1 = PIN_I;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int p = 0; p < pin_mux_pkg::PIN_COUNT; p++) begin
      if (s_q.sync2[p] == s_q.sync3[p]) begin
        s_d.pin_in[p] = s_q.sync3[p];
      end
    end
    changed = s_d.pin_in ^ s_q.pin_in;
    // output only if grouped and enabled
    s_d.pin_out_r = pin_drive & s_q.oe;
    s_d.pin_oe_n = ~s_q.oe;
    if (WR) begin
      case (ADDR)
        pin_mux_pkg::REG_OE: s_d.oe = WDATA[18:0];
        pin_mux_pkg::REG_FUNC: s_d.func = WDATA[19:0];
        pin_mux_pkg::REG_WATCH_IDX: s_d.watch_idx = WDATA[7:0];
        pin_mux_pkg::REG_WATCH_MASK: s_d.watch_mask = WDATA[7:0];
        pin_mux_pkg::REG_PIN_OUT: s_d.pin_out = WDATA[18:0];
        pin_mux_pkg::REG_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~WDATA[18:0];
        pin_mux_pkg::REG_IRQ_MASK: s_d.irq_mask = WDATA[18:0];
        default: ;
      endcase
    end
    // set wins over write-one clear
    s_d.irq_stat = s_d.irq_stat | changed;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    s_d.rdata = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        pin_mux_pkg::REG_OE: s_d.rdata = {13'h0000, s_q.oe};
        pin_mux_pkg::REG_FUNC: s_d.rdata = {12'h000, s_q.func};
        pin_mux_pkg::REG_WATCH_IDX: s_d.rdata = {24'h000000, s_q.watch_idx};
        pin_mux_pkg::REG_WATCH_MASK: s_d.rdata = {24'h000000, s_q.watch_mask};
        pin_mux_pkg::REG_PIN_OUT: s_d.rdata = {13'h0000, s_q.pin_out};
        pin_mux_pkg::REG_PIN_IN: s_d.rdata = {13'h0000, s_q.pin_in};
        pin_mux_pkg::REG_IRQ_STAT: s_d.rdata = {13'h0000, s_q.irq_stat};
        pin_mux_pkg::REG_IRQ_MASK: s_d.rdata = {13'h0000, s_q.irq_mask};
        pin_mux_pkg::REG_WATCH_WORD: s_d.rdata = {24'h000000, word};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; reset is synchronous and gated by clock enable
  always_ff @(posedge CLK_SYS) begin
    if (CE) begin
      if (!NRST) begin
        s_q <= '0;
        s_q.oe <= pin_mux_pkg::OE_RESET;
        s_q.func <= {pin_mux_pkg::GROUP_COUNT{pin_mux_pkg::FUNC_RESET}};
        s_q.watch_idx <= pin_mux_pkg::IDX_RESET;
        s_q.watch_mask <= pin_mux_pkg::MASK_RESET;
        s_q.pin_oe_n <= ~pin_mux_pkg::OE_RESET;
      end else begin
        s_q <= s_d;
      end
    end
  end

  // outputs straight from flip-flops
  assign RDATA = s_q.rdata;
  assign PIN_O = s_q.pin_out_r;
  assign PIN_OE_N = s_q.pin_oe_n;
  assign CPU_IN = s_q.pin_in;
  assign IRQ = s_q.irq;
endmodule : pin_function_mux
`default_nettype wire

// ### testbench/bbp_model.sv
`timescale 1ns/10ps
`default_nettype none
module bbp_model (
  input wire logic [18:0] pin_o, // device level
  input wire logic [18:0] pin_oe_n, // low: device drives
  input wire logic [18:0] drv, // processor level
  output logic [18:0] pin_i // resolved pin
);
  // per pin direction
  // device wins where enabled, so contention is never seen
  assign pin_i = (pin_o & ~pin_oe_n) | (drv & pin_oe_n);
endmodule : bbp_model
`default_nettype wire

// ### testbench/pin_function_mux_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pin_mux_checker (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic [18:0] PIN_O,
  input wire logic [18:0] PIN_OE_N,
  input wire logic IRQ
);
  logic [19:0] func_q;
  logic [7:0] idx_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // shadow of function and index writes
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      func_q <= 20'h00000;
      idx_q <= 8'h00;
    end else if (WR && ADDR == pin_mux_pkg::REG_FUNC) func_q <= WDATA[19:0];
    else if (WR && ADDR == pin_mux_pkg::REG_WATCH_IDX) idx_q <= WDATA[7:0];
  end
  oe_follow_a: assert property (WR && ADDR == pin_mux_pkg::REG_OE |-> ##2 PIN_OE_N == ~$past(WDATA[18:0], 2))
    else $error("enable not taken");
  oe_change_a: assert property ($changed(PIN_OE_N) |-> $past(WR && ADDR == pin_mux_pkg::REG_OE, 2))
    else $error("enable moved");
  drive_gate_a: assert property ((PIN_O & PIN_OE_N) == 19'h00000)
    else $error("undriven pin high");
  mask_zero_a: assert property (RD && ADDR == pin_mux_pkg::REG_WATCH_WORD
    && $past(WR && ADDR == pin_mux_pkg::REG_WATCH_MASK && WDATA[7:0] == 8'h00, 2) |=> RDATA == 32'h0)
    else $error("mask ignored");
  reset_state_a: assert property (disable iff (1'b0) !NRST |=> &PIN_OE_N && PIN_O == 19'h0 && !IRQ)
    else $error("bad reset state");
  watch_map_a: assert property (func_q == 20'h0 && PIN_OE_N == 19'h0
    |=> PIN_O[18:16] == PIN_O[6:4] && PIN_O[15:8] == PIN_O[7:0]) else $error("watch map");
  unused_bits_a: assert property (RD && ADDR == pin_mux_pkg::REG_WATCH_WORD
    && idx_q == pin_mux_pkg::WATCH_SET_D |=> RDATA[4:3] == 2'b00) else $error("unused bits set");
endmodule : pin_mux_checker
bind pin_function_mux pin_mux_checker chk_i (.CLK_SYS, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .PIN_O, .PIN_OE_N, .IRQ);
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic CE = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  pin_mux_pkg::chan_status_t CH1 = '0;
  pin_mux_pkg::chan_status_t CH2 = '0;
  logic [18:0] CPU_OUT = 19'h12345;
  logic [18:0] SLICER_OUT = 19'h6789A;
  logic [18:0] drv = 19'h3C3C3;
  logic [18:0] CPU_IN, PIN_I, PIN_O, PIN_OE_N;
  logic IRQ;
  logic [7:0] w;
  logic [7:0] ex [6] = '{8'hAA, 8'hA8, 8'h00, 8'h55, 8'h54, 8'hE7};
  logic [7:0] ix [3] = '{8'h01, 8'h02, 8'h04};
  int error_cnt = 0;
  int samples_checked = 0;
  // 10 MHz clock
  always #50 CLK_SYS = ~CLK_SYS;
  pin_function_mux uut (.CLK_SYS, .NRST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .CH1, .CH2, .CPU_OUT,
    .SLICER_OUT, .CPU_IN, .PIN_I, .PIN_O, .PIN_OE_N, .IRQ);
  bbp_model far (.pin_o(PIN_O), .pin_oe_n(PIN_OE_N), .drv, .pin_i(PIN_I));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    chk(RDATA, e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask : idle
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // watchdog, the sequence needs well under 1 ms
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    idle(1);
    chk(32'(PIN_OE_N), 32'h7FFFF);
    rd(pin_mux_pkg::REG_FUNC, 32'h0);
    rd(pin_mux_pkg::REG_WATCH_MASK, 32'hFF);
    // manual levels out, readback on inputs
    wr(pin_mux_pkg::REG_FUNC, 32'h33333);
    wr(pin_mux_pkg::REG_PIN_OUT, 32'h5A5A5);
    wr(pin_mux_pkg::REG_OE, 32'h0F0F0);
    idle(8);
    chk(32'(PIN_O), 32'h0A0A0);
    rd(pin_mux_pkg::REG_PIN_IN, 32'h3A3A3);
    chk(32'(CPU_IN), 32'h3A3A3);
    // each watch set with either channel active
    wr(pin_mux_pkg::REG_FUNC, 32'h0);
    wr(pin_mux_pkg::REG_OE, 32'h7FFFF);
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK_SYS);
      CH1 <= {11{i > 2}};
      CH2 <= {11{i <= 2}};
      wr(pin_mux_pkg::REG_WATCH_IDX, {24'h0, ix[i % 3]});
      w = ex[i];
      idle(4);
      rd(pin_mux_pkg::REG_WATCH_WORD, {24'h0, w});
      chk(32'(PIN_O), {13'h0, w[6:4], w, w});
    end
    wr(pin_mux_pkg::REG_WATCH_MASK, 32'h0F);
    idle(4);
    chk(32'(PIN_O), 32'h00707);
    wr(pin_mux_pkg::REG_WATCH_MASK, 32'h0);
    rd(pin_mux_pkg::REG_WATCH_WORD, 32'h0);
    wr(pin_mux_pkg::REG_WATCH_MASK, 32'hFF);
    // groups 0..4 on codes 0, 3, 9, 10, 3
    wr(pin_mux_pkg::REG_FUNC, 32'h3A930);
    idle(4);
    chk(32'(PIN_O), 32'h573A7);
    // pin change events, masked and cleared
    wr(pin_mux_pkg::REG_OE, 32'h0);
    idle(8);
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h7FFFF);
    wr(pin_mux_pkg::REG_IRQ_MASK, 32'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK_SYS);
      drv <= drv ^ (19'h1 << i);
      idle(8);
      chk(32'(IRQ), 32'(i));
    end
    rd(pin_mux_pkg::REG_IRQ_STAT, 32'h3);
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h2);
    idle(3);
    chk(32'(IRQ), 32'h0);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF, 32'h0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
